// File: evt_pulse_consts.svh
// Constants for the event timestamp and timing pulse unit
`ifndef EVT_PULSE_CONSTS_SVH
`define EVT_PULSE_CONSTS_SVH
// =====================================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_UNL_RATE    8'h04
`define OFS_UNL_WIDTH   8'h08
`define OFS_LCK_RATE    8'h0c
`define OFS_LCK_WIDTH   8'h10
`define OFS_CABLE_DLY   8'h14
`define OFS_USER_DLY    8'h18
`define OFS_STATUS      8'h1c
`define OFS_RISE_TIME   8'h20
`define OFS_FALL_TIME   8'h24
`define OFS_MARK_COUNT  8'h28
`define OFS_NEXT_PULSE  8'h2c
`define OFS_TIME_LO     8'h30
`define OFS_TIME_HI     8'h34
`define OFS_RTC_SEC     8'h38
`define OFS_ASSIST_SEC  8'h3c
`define OFS_ACCURACY    8'h40
// =====================================================================
// Control bit positions
`define CTL_PULSE_EN    0
`define CTL_RATE_FREQ   1
`define CTL_WIDTH_PCT   2
`define CTL_USE_LOCKED  3
`define CTL_LOCK_FREQ   4
`define CTL_ALIGN_SEC   5
`define CTL_POLARITY    6
`define CTL_REPORT_EN   7
`define CTL_ASSIST_ARM  8
`define CTL_GRID_LSB    12
`define CTL_GRID_MSB    14
`define CTL_RESET_VAL   32'h0000_0000
// Status bit positions
`define ST_TIME_VALID   0
`define ST_NEW_RISE     1
`define ST_NEW_FALL     2
`define ST_REPORT       3
`define ST_TP_REPORT    4
`define ST_LEVEL        5
// =====================================================================
// Timing
`define CLK_PERIOD_NS   10
`define NS_PER_US       1000
`define MIN_PHASE_NS    50
`define MIN_PHASE_CYC   ((`MIN_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PER_US      (`NS_PER_US / `CLK_PERIOD_NS)
`define CYC_PER_SEC     100000000
`define DEF_PERIOD_US   1000000
`define DEF_WIDTH_US    100000
`endif

// File: evt_pulse_pkg.sv
// Types for the event timestamp and timing pulse unit
package evt_pulse_pkg;
  typedef enum logic [2:0]
  {
    GRID_UTC, GRID_GPS, GRID_GLO, GRID_BDS, GRID_GAL, GRID_NAVIC
  } time_grid_t;
  typedef enum {PH_IDLE, PH_LEAD, PH_TRAIL} pulse_phase_t;
endpackage : evt_pulse_pkg

// File: event_timestamp_and_pulse_gen.sv
// Event timestamp capture and configurable timing pulse generator
//
// Operation
// - At each epoch emit a timestamp report if enabled and an edge occurred.
// - Keep only the latest rising and latest falling timestamp per epoch.
// - Report carries times, new-edge flags, source, validity, mark count, accuracy.
// - Timestamps use the selected time base and the same delay corrections.
// - Pulse output toggles only while pulse enable is set.
// - Selectors choose frequency or period, and microseconds or duty percentage.
// - Unlocked settings apply when use-locked is clear or time is not valid.
// - Locked settings apply once time is valid and use-locked is set.
// - Lock-to-satellite-frequency times pulses from the recovered frequency tick.
// - Align setting puts pulse edges on whole seconds, only while time is valid.
// - Polarity set means rising leading edge, clear means falling.
// - Grid codes UTC 0, GPS 1, GLONASS 2, BeiDou 3, Galileo 4, NAVIC 5.
// - Pulse width is clamped to never exceed the period.
// - High and low phases each last at least 50 ns.
// - Pulse edges shift by cable delay plus user delay, when aligned to whole seconds.
// - Equal 1 s period and 100 ms width in both states keep 1 Hz.
// - Before each pulse but the first after enable, emit a next-pulse time report with time source.
// - Host sets measurement and pulse rate to 1 Hz to pair reports.
// - Assist pulse on event input applies supplied coarse time at that instant.
// - Battery-domain seconds clock seeds receiver time at power-up.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`include "evt_pulse_consts.svh"

module event_timestamp_and_pulse_gen
  import evt_pulse_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = `CYC_PER_SEC
)
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        i_event_input_pin,
  input  wire logic        i_epoch,
  input  wire logic        i_time_valid,
  input  wire logic        i_sat_freq_tick,
  input  wire logic [31:0] i_rtc_seconds,
  output logic             o_timing_pulse_output,
  output logic             o_event_report,
  output logic             o_next_pulse_report
);

  // =====================================================================
  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] unl_rate_reg;
  logic [31:0] unl_width_reg;
  logic [31:0] lck_rate_reg;
  logic [31:0] lck_width_reg;
  logic [31:0] cable_dly_reg;
  logic [31:0] user_dly_reg;
  logic [31:0] assist_sec_reg;
  logic [31:0] accuracy_reg;
  logic [31:0] rise_time_reg;
  logic [31:0] fall_time_reg;
  logic [31:0] mark_count_reg;
  logic [31:0] next_pulse_reg;
  logic [63:0] time_reg;
  logic        new_rise_reg;
  logic        new_fall_reg;
  logic        report_reg;
  logic        tp_report_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        seeded_reg;

  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rd_next;
  logic [31:0] wmask;

  assign wr_stb = CYC_I & STB_I & WE_I & ack_reg;
  assign rd_stb = CYC_I & STB_I & ~WE_I & ~ack_reg;
  assign wmask  = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old_v & ~m) | (d & m);
  endfunction : merge

  // =====================================================================
  // Configuration writes
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ctrl_reg      <= `CTL_RESET_VAL;
      unl_rate_reg  <= 32'(`DEF_PERIOD_US);
      unl_width_reg <= 32'(`DEF_WIDTH_US);
      lck_rate_reg  <= 32'(`DEF_PERIOD_US);
      lck_width_reg <= 32'(`DEF_WIDTH_US);
      cable_dly_reg <= 32'h0000_0000;
      user_dly_reg  <= 32'h0000_0000;
      assist_sec_reg <= 32'h0000_0000;
      accuracy_reg  <= 32'h0000_0000;
    end
    else if (wr_stb)
    begin
      if (ADR_I == `OFS_CTRL) ctrl_reg <= merge(ctrl_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_UNL_RATE) unl_rate_reg <= merge(unl_rate_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_UNL_WIDTH) unl_width_reg <= merge(unl_width_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_LCK_RATE) lck_rate_reg <= merge(lck_rate_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_LCK_WIDTH) lck_width_reg <= merge(lck_width_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_CABLE_DLY) cable_dly_reg <= merge(cable_dly_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_USER_DLY) user_dly_reg <= merge(user_dly_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_ASSIST_SEC) assist_sec_reg <= merge(assist_sec_reg, wmask, DAT_I);
      else if (ADR_I == `OFS_ACCURACY) accuracy_reg <= merge(accuracy_reg, wmask, DAT_I);
    end
  end

  logic       pulse_en;
  logic       use_locked;
  logic       locked_sel;
  logic       assist_arm_set;
  time_grid_t grid;
  assign pulse_en   = ctrl_reg[`CTL_PULSE_EN];
  assign use_locked = ctrl_reg[`CTL_USE_LOCKED];
  assign grid       = time_grid_t'(ctrl_reg[`CTL_GRID_MSB:`CTL_GRID_LSB]);
  assign locked_sel = use_locked & i_time_valid;
  assign assist_arm_set = wr_stb & (ADR_I == `OFS_CTRL) & SEL_I[1] & DAT_I[`CTL_ASSIST_ARM];

  // =====================================================================
  // Event input synchroniser and edge detect
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic rise_det;
  logic fall_det;
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= i_event_input_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  assign rise_det = sync2_reg & ~sync3_reg;
  assign fall_det = ~sync2_reg & sync3_reg;

  // =====================================================================
  // Local time base, in nanoseconds of the selected grid
  logic [63:0] stamp_now;
  logic        assist_armed_reg;
  // Timestamps back out the output-side delays so marks and pulses agree
  assign stamp_now = time_reg - 64'(cable_dly_reg) - 64'(user_dly_reg);

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      time_reg         <= 64'h0;
      seeded_reg       <= 1'b0;
      assist_armed_reg <= 1'b0;
    end
    else
    begin
      if (!seeded_reg)
      begin
        time_reg   <= 64'(i_rtc_seconds) * 64'(CYC_PER_SEC) * 64'(`CLK_PERIOD_NS);
        seeded_reg <= 1'b1;
      end
      else if (assist_armed_reg && rise_det)
        time_reg <= 64'(assist_sec_reg) * 64'(CYC_PER_SEC) * 64'(`CLK_PERIOD_NS);
      else
        time_reg <= time_reg + 64'(`CLK_PERIOD_NS);
      if (assist_armed_reg && rise_det)
        assist_armed_reg <= 1'b0;
      else if (assist_arm_set)
        assist_armed_reg <= 1'b1;
    end
  end

  // =====================================================================
  // Mark capture and epoch report
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rise_time_reg  <= 32'h0;
      fall_time_reg  <= 32'h0;
      mark_count_reg <= 32'h0;
      new_rise_reg   <= 1'b0;
      new_fall_reg   <= 1'b0;
      report_reg     <= 1'b0;
    end
    else
    begin
      report_reg <= i_epoch & ctrl_reg[`CTL_REPORT_EN] & (new_rise_reg | new_fall_reg);
      if (rise_det)
        rise_time_reg <= stamp_now[31:0];
      if (fall_det)
        fall_time_reg <= stamp_now[31:0];
      if (rise_det || fall_det)
        mark_count_reg <= mark_count_reg + 32'h1;
      // An edge in the epoch cycle survives into the next interval
      if (rise_det)
        new_rise_reg <= 1'b1;
      else if (i_epoch && ctrl_reg[`CTL_REPORT_EN])
        new_rise_reg <= 1'b0;
      if (fall_det)
        new_fall_reg <= 1'b1;
      else if (i_epoch && ctrl_reg[`CTL_REPORT_EN])
        new_fall_reg <= 1'b0;
    end
  end

  // =====================================================================
  // Pulse timing: period and width in clock cycles
  logic [31:0] rate_v;
  logic [31:0] width_v;
  logic [31:0] period_cyc;
  logic [31:0] width_cyc;
  logic [31:0] width_clamped;
  logic [31:0] delay_cyc;
  always_comb
  begin
    rate_v  = locked_sel ? lck_rate_reg : unl_rate_reg;
    width_v = locked_sel ? lck_width_reg : unl_width_reg;
    if (ctrl_reg[`CTL_RATE_FREQ])
      period_cyc = (rate_v == 32'h0) ? 32'h0 : 32'(CYC_PER_SEC) / rate_v;
    else
      period_cyc = 32'(64'(rate_v) * 64'(`CYC_PER_US));
    if (ctrl_reg[`CTL_WIDTH_PCT])
      width_cyc = 32'((64'(period_cyc) * 64'(width_v)) / 64'd100);
    else
      width_cyc = 32'(64'(width_v) * 64'(`CYC_PER_US));
    // Keep both phases at least the minimum; a too-short period disables output
    if (width_cyc > period_cyc)
      width_clamped = period_cyc;
    else
      width_clamped = width_cyc;
    if (width_clamped != 32'h0 && width_clamped < 32'(`MIN_PHASE_CYC))
      width_clamped = 32'(`MIN_PHASE_CYC);
    if (width_clamped != 32'h0 && period_cyc - width_clamped < 32'(`MIN_PHASE_CYC))
      width_clamped = period_cyc - 32'(`MIN_PHASE_CYC);
    delay_cyc = (cable_dly_reg + user_dly_reg) / 32'(`CLK_PERIOD_NS);
  end

  // =====================================================================
  // Pulse generator
  pulse_phase_t phase_reg;
  logic [31:0]  cnt_reg;
  logic [31:0]  sec_cnt_reg;
  logic         tick;
  logic         sec_edge;
  logic         active_reg;
  logic         pulse_ok;
  // Satellite-frequency tick gates the count when selected
  assign tick     = ctrl_reg[`CTL_LOCK_FREQ] ? i_sat_freq_tick : 1'b1;
  assign sec_edge = tick && (sec_cnt_reg == delay_cyc % 32'(CYC_PER_SEC));
  assign pulse_ok = pulse_en && period_cyc >= 32'(2 * `MIN_PHASE_CYC)
                    && width_clamped != 32'h0;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      phase_reg     <= PH_IDLE;
      cnt_reg       <= 32'h0;
      sec_cnt_reg   <= 32'h0;
      active_reg    <= 1'b0;
      tp_report_reg <= 1'b0;
      next_pulse_reg <= 32'h0;
    end
    else
    begin
      tp_report_reg <= 1'b0;
      if (tick)
        sec_cnt_reg <= (sec_cnt_reg >= 32'(CYC_PER_SEC) - 32'h1) ? 32'h0 : sec_cnt_reg + 32'h1;
      case (phase_reg)
        PH_IDLE:
        begin
          active_reg <= 1'b0;
          // Align waits for the second mark only while time is valid
          if (pulse_ok && (!ctrl_reg[`CTL_ALIGN_SEC] || !i_time_valid || sec_edge))
          begin
            phase_reg <= PH_LEAD;
            cnt_reg   <= 32'h0;
          end
        end
        PH_LEAD:
        begin
          if (!pulse_ok)
            phase_reg <= PH_IDLE;
          else if (tick)
          begin
            active_reg <= (cnt_reg < width_clamped);
            if (cnt_reg == period_cyc - 32'h2)
            begin
              tp_report_reg  <= 1'b1;
              next_pulse_reg <= 32'(time_reg + 64'(2 * `CLK_PERIOD_NS));
            end
            if (cnt_reg >= period_cyc - 32'h1)
            begin
              cnt_reg   <= 32'h0;
              phase_reg <= (ctrl_reg[`CTL_ALIGN_SEC] && i_time_valid) ? PH_TRAIL : PH_LEAD;
            end
            else
              cnt_reg <= cnt_reg + 32'h1;
          end
        end
        PH_TRAIL:
        begin
          active_reg <= 1'b0;
          // Resynchronise to the second mark each period while aligned
          if (!pulse_ok)
            phase_reg <= PH_IDLE;
          else if (sec_edge || !ctrl_reg[`CTL_ALIGN_SEC] || !i_time_valid)
            phase_reg <= PH_LEAD;
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      o_timing_pulse_output <= 1'b0;
    else if (!pulse_en)
      o_timing_pulse_output <= ~ctrl_reg[`CTL_POLARITY];
    else
      o_timing_pulse_output <= active_reg ~^ ctrl_reg[`CTL_POLARITY];
  end

  assign o_event_report      = report_reg;
  assign o_next_pulse_report = tp_report_reg;

  // =====================================================================
  // Wishbone read and acknowledge
  always_comb
  begin
    rd_next = 32'h0;
    if (ADR_I == `OFS_CTRL) rd_next = ctrl_reg;
    else if (ADR_I == `OFS_UNL_RATE) rd_next = unl_rate_reg;
    else if (ADR_I == `OFS_UNL_WIDTH) rd_next = unl_width_reg;
    else if (ADR_I == `OFS_LCK_RATE) rd_next = lck_rate_reg;
    else if (ADR_I == `OFS_LCK_WIDTH) rd_next = lck_width_reg;
    else if (ADR_I == `OFS_CABLE_DLY) rd_next = cable_dly_reg;
    else if (ADR_I == `OFS_USER_DLY) rd_next = user_dly_reg;
    else if (ADR_I == `OFS_STATUS)
    begin
      rd_next[`ST_TIME_VALID] = i_time_valid;
      rd_next[`ST_NEW_RISE]   = new_rise_reg;
      rd_next[`ST_NEW_FALL]   = new_fall_reg;
      rd_next[`ST_REPORT]     = report_reg;
      rd_next[`ST_TP_REPORT]  = tp_report_reg;
      rd_next[`ST_LEVEL]      = o_timing_pulse_output;
      rd_next[10:8]           = grid;
    end
    else if (ADR_I == `OFS_RISE_TIME) rd_next = rise_time_reg;
    else if (ADR_I == `OFS_FALL_TIME) rd_next = fall_time_reg;
    else if (ADR_I == `OFS_MARK_COUNT) rd_next = mark_count_reg;
    else if (ADR_I == `OFS_NEXT_PULSE) rd_next = next_pulse_reg;
    else if (ADR_I == `OFS_TIME_LO) rd_next = time_reg[31:0];
    else if (ADR_I == `OFS_TIME_HI) rd_next = time_reg[63:32];
    else if (ADR_I == `OFS_RTC_SEC) rd_next = i_rtc_seconds;
    else if (ADR_I == `OFS_ASSIST_SEC) rd_next = assist_sec_reg;
    else if (ADR_I == `OFS_ACCURACY) rd_next = accuracy_reg;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= CYC_I & STB_I & ~ack_reg;
      if (rd_stb)
        dat_reg <= rd_next;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

endmodule : event_timestamp_and_pulse_gen

// File: event_timestamp_and_pulse_gen_sva.sv
// Assertion checker for the event timestamp and timing pulse unit
`include "evt_pulse_consts.svh"

module evt_pulse_chk
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_ARST_N,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic        ACK_O,
  input wire logic        i_epoch,
  input wire logic        i_time_valid,
  input wire logic        o_timing_pulse_output,
  input wire logic        o_event_report,
  input wire logic        o_next_pulse_report
);
  // ====================
  // Shadow of the control word
  logic [31:0] ctl_reg;
  logic [7:0]  quiet_reg;
  logic        settled;
  logic        pol;

  assign pol     = ctl_reg[`CTL_POLARITY];
  // Any write or lock change may legally reshape the current period, so wait it out
  assign settled = quiet_reg == 8'hff;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    if (!I_ARST_N)
      ctl_reg <= '0;
    else if (CYC_I && STB_I && WE_I && ACK_O && ADR_I == `OFS_CTRL)
      ctl_reg <= DAT_I;

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    if (!I_ARST_N)
      quiet_reg <= '0;
    else if ((CYC_I && STB_I && WE_I && ACK_O) || $changed(i_time_valid))
      quiet_reg <= '0;
    else if (!settled)
      quiet_reg <= quiet_reg + 8'h1;

  // ====================
  // Properties
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing");
  a_ack_source: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  a_report_epoch: assert property (o_event_report |-> $past(i_epoch) && ctl_reg[`CTL_REPORT_EN])
    else $error("event report without epoch");
  a_idle_off: assert property (settled && !ctl_reg[`CTL_PULSE_EN] |-> o_timing_pulse_output == !pol)
    else $error("pulse output not idle");
  a_min_high: assert property ($rose(o_timing_pulse_output) && settled |=> (o_timing_pulse_output || !settled)[*4])
    else $error("high phase too short");
  a_min_low: assert property ($fell(o_timing_pulse_output) && settled |=> (!o_timing_pulse_output || !settled)[*4])
    else $error("low phase too short");
  a_tp_lead: assert property (o_next_pulse_report && settled && ctl_reg[`CTL_PULSE_EN] |-> ##[1:5] (($changed(o_timing_pulse_output) && o_timing_pulse_output == pol) || !settled))
    else $error("no leading edge after next-pulse report");

  c_report: cover property (o_event_report);
  c_lead: cover property (o_next_pulse_report ##[1:3] $changed(o_timing_pulse_output));
  c_rise_pol: cover property ($rose(o_timing_pulse_output) && pol && settled);
endmodule : evt_pulse_chk

bind event_timestamp_and_pulse_gen evt_pulse_chk u_chk
(
  .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .i_epoch(i_epoch), .i_time_valid(i_time_valid),
  .o_timing_pulse_output(o_timing_pulse_output), .o_event_report(o_event_report),
  .o_next_pulse_report(o_next_pulse_report)
);

// File: event_host_model.sv
// Host model: pulses the event pin and counts leading edges of the timing pulse
module event_host_model
(
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [7:0]  i_high_cyc,
  input  wire logic        i_pulse,
  input  wire logic        i_pol,
  output logic             o_pin,
  output logic [15:0]      o_edges
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Event pin driver
  logic [7:0] cnt_reg = '0;
  logic       last_reg = 1'b0;
  logic [7:0] high_cyc;

  // A start is refused for 200 cycles so the pin never exceeds 500 kHz
  assign high_cyc = (i_high_cyc < 8'h5) ? 8'h5 : i_high_cyc;
  assign o_pin    = cnt_reg != 8'h0 && cnt_reg <= high_cyc;
  initial o_edges = '0;

  always @(posedge i_clk)
  begin
    if (cnt_reg == 8'h0)
      cnt_reg <= i_go ? 8'h1 : 8'h0;
    else
      cnt_reg <= (cnt_reg == 8'hc8) ? 8'h0 : cnt_reg + 8'h1;
    last_reg <= i_pulse;
    if (i_pulse == i_pol && last_reg != i_pol)
      o_edges <= o_edges + 16'h1;
  end
endmodule : event_host_model

// File: tb_event_timestamp_and_pulse_gen.sv
// Self-checking bench for the event timestamp and timing pulse unit
`include "evt_pulse_consts.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

module tb_event_timestamp_and_pulse_gen;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Stimulus and wiring
  localparam logic [31:0] C_EN  = 32'h1 << `CTL_PULSE_EN;
  localparam logic [31:0] C_FRQ = 32'h1 << `CTL_RATE_FREQ;
  localparam logic [31:0] C_PCT = 32'h1 << `CTL_WIDTH_PCT;
  localparam logic [31:0] C_LCK = 32'h1 << `CTL_USE_LOCKED;
  localparam logic [31:0] C_SAT = 32'h1 << `CTL_LOCK_FREQ;
  localparam logic [31:0] C_POL = 32'h1 << `CTL_POLARITY;
  localparam logic [31:0] C_REP = 32'h1 << `CTL_REPORT_EN;
  localparam logic [31:0] C_ARM = 32'h1 << `CTL_ASSIST_ARM;
  localparam int          SIM_SEC = 1000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic        ack;
  logic        ep = 1'b0;
  logic        tvalid = 1'b0;
  logic        go = 1'b0;
  logic        hpol = 1'b1;
  logic        sat_tick = 1'b0;
  logic        pin;
  logic        tp;
  logic        erep;
  logic        nrep;
  logic [15:0] edges;
  int          errors = 0;
  int          n_compared = 0;
  int          nrep_cnt = 0;

  always #5 clk = ~clk;
  // Half-rate satellite tick so lock-to-satellite timing differs from the clock
  always @(posedge clk)
    sat_tick <= ~sat_tick;
  always @(posedge clk)
    if (nrep === 1'b1)
      nrep_cnt++;

  event_timestamp_and_pulse_gen #(.CYC_PER_SEC(SIM_SEC)) dut
  (
    .I_SYS_CLK(clk), .I_ARST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .i_event_input_pin(pin),
    .i_epoch(ep), .i_time_valid(tvalid), .i_sat_freq_tick(sat_tick),
    .i_rtc_seconds(32'h0000_1234), .o_timing_pulse_output(tp), .o_event_report(erep),
    .o_next_pulse_report(nrep)
  );

  event_host_model host
  (
    .i_clk(clk), .i_go(go), .i_high_cyc(8'h14), .i_pulse(tp), .i_pol(hpol), .o_pin(pin),
    .o_edges(edges)
  );

  // ====================
  // Bus and measurement tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 50 && ack !== 1'b1; n++)
      @(posedge clk);
    q = rdat;
    `CHK("bus ack", 1'b1, ack)
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    wb(1'b0, a, '0, q);
    `CHK(nm, ex, q)
  endtask : rd_chk

  task automatic measure(input logic pol, output int act, output int per);
    int n;
    for (n = 0; n < 3000 && tp === pol; n++)
      @(posedge clk);
    for (n = 0; n < 3000 && tp !== pol; n++)
      @(posedge clk);
    for (act = 0; act < 3000 && tp === pol; act++)
      @(posedge clk);
    for (per = act; per < 3000 && tp !== pol; per++)
      @(posedge clk);
  endtask : measure

  task automatic pulse_case(input logic [31:0] ctl, input int ea, input int ep_cyc);
    int a;
    int p;
    int e0;
    int n0;
    hpol <= ctl[`CTL_POLARITY];
    wr(`OFS_CTRL, ctl);
    measure(ctl[`CTL_POLARITY], a, p);
    e0 = edges;
    n0 = nrep_cnt;
    measure(ctl[`CTL_POLARITY], a, p);
    `CHK("active cycles", ea, a)
    `CHK("period cycles", ep_cyc, p)
    `CHK("pulses paired", edges - e0, nrep_cnt - n0)
  endtask : pulse_case

  task automatic idle_case(input logic lvl);
    int n;
    int bad;
    bad = 0;
    // The output is registered one cycle behind the control write
    @(posedge clk);
    for (n = 0; n < 300; n++)
    begin
      @(posedge clk);
      bad += (tp !== lvl);
    end
    `CHK("idle level", 0, bad)
  endtask : idle_case

  task automatic epoch(output logic seen);
    @(posedge clk);
    ep <= 1'b1;
    @(posedge clk);
    ep <= 1'b0;
    seen = 1'b0;
    repeat (3)
    begin
      @(posedge clk);
      seen = seen | erep;
    end
  endtask : epoch

  task automatic mark();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (220) @(posedge clk);
  endtask : mark

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    stop_test();
  end

  // ====================
  // Tests
  initial
  begin
    logic [31:0] q;
    logic [31:0] r1;
    logic s;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl reset", `OFS_CTRL, `CTL_RESET_VAL);
    rd_chk("rtc seed", `OFS_RTC_SEC, 32'h0000_1234);
    wr(8'h80, 32'hffff_ffff);
    rd_chk("unmapped", 8'h80, 32'h0);
    idle_case(1'b1);
    $display("test reset done");
    wr(`OFS_UNL_RATE, 32'h2);
    wr(`OFS_UNL_WIDTH, 32'h1);
    pulse_case(C_EN | C_POL, 100, 200);
    pulse_case(C_EN, 100, 200);
    wr(`OFS_LCK_RATE, 32'h2);
    wr(`OFS_LCK_WIDTH, 32'h1);
    tvalid <= 1'b1;
    pulse_case(C_EN | C_POL | C_LCK, 100, 200);
    wr(`OFS_UNL_WIDTH, 32'd25);
    wr(`OFS_LCK_RATE, 32'h1);
    wr(`OFS_LCK_WIDTH, 32'd20);
    pulse_case(C_EN | C_POL | C_PCT, 50, 200);
    pulse_case(C_EN | C_POL | C_PCT | C_LCK | C_SAT, 40, 200);
    tvalid <= 1'b0;
    pulse_case(C_EN | C_POL | C_PCT | C_LCK, 50, 200);
    wr(`OFS_UNL_RATE, 32'd5);
    pulse_case(C_EN | C_POL | C_PCT | C_FRQ, 50, 200);
    wr(`OFS_CTRL, C_POL);
    idle_case(1'b0);
    $display("test pulse done");
    wr(`OFS_CTRL, C_REP | (32'h5 << `CTL_GRID_LSB));
    rd_chk("count start", `OFS_MARK_COUNT, 32'h0);
    epoch(s);
    `CHK("report without edge", 1'b0, s)
    mark();
    rd_chk("count one mark", `OFS_MARK_COUNT, 32'h2);
    wb(1'b0, `OFS_STATUS, '0, q);
    `CHK("new edge flags", 2'b11, q[2:1])
    `CHK("grid code", 3'h5, q[10:8])
    wb(1'b0, `OFS_RISE_TIME, '0, r1);
    mark();
    wb(1'b0, `OFS_RISE_TIME, '0, q);
    `CHK("latest rise kept", 1'b1, q > r1)
    rd_chk("count two marks", `OFS_MARK_COUNT, 32'h4);
    epoch(s);
    `CHK("report after edges", 1'b1, s)
    wb(1'b0, `OFS_STATUS, '0, q);
    `CHK("flags cleared", 2'b00, q[2:1])
    epoch(s);
    `CHK("no repeat report", 1'b0, s)
    wr(`OFS_CTRL, 32'h0);
    mark();
    epoch(s);
    `CHK("report disabled", 1'b0, s)
    $display("test marks done");
    wr(`OFS_ASSIST_SEC, 32'h0000_0100);
    wr(`OFS_CTRL, C_ARM);
    mark();
    wb(1'b0, `OFS_TIME_LO, '0, q);
    `CHK("assisted time", 1'b1, q - 32'(256 * SIM_SEC * `CLK_PERIOD_NS) < 32'd3000)
    $display("test assist done");
    stop_test();
  end
endmodule : tb_event_timestamp_and_pulse_gen
